// *** src/lm_pkg.sv ***
// Shared constants and types of the limit monitor and event logger
package lm_pkg;
  // Timing
  localparam int          CLK_HZ    = 100_000_000;
  localparam int          SEC_S     = 1;
  localparam int          SEC_CYC   = SEC_S * CLK_HZ;
  localparam int          HOUR_S    = 3600;
  localparam logic [11:0] HOUR_LAST = 12'(HOUR_S - 1);
  // Sizes
  localparam int          NGRP      = 2;
  localparam int          NCMP      = 3;
  localparam int          NALL      = NGRP * NCMP;
  localparam int          NBLK      = 32768;
  localparam int          P4_BYTES  = 10;
  localparam logic [3:0]  P4_LAST   = 4'(P4_BYTES - 1);
  // Block layout, byte offsets
  localparam logic [4:0]  OFS_REC   = 5'h00;
  localparam logic [4:0]  OFS_TS    = 5'h02;
  localparam logic [4:0]  OFS_DATA  = 5'h06;
  localparam logic [4:0]  OFS_PROF  = 5'h10;
  localparam logic [4:0]  OFS_ERR   = 5'h11;
  localparam logic [4:0]  BLK_LEN   = 5'h12;
  // Field codes
  localparam logic [9:0]  SEL_OFF   = 10'h000;
  localparam logic [9:0]  SEL_EXT   = 10'h001;
  localparam logic [9:0]  SEL_LO    = 10'h0C8;
  localparam logic [9:0]  SEL_HI    = 10'h190;
  localparam logic        OP_GE     = 1'b0;
  localparam logic [7:0]  ERR_OK    = 8'h00;
  localparam logic [7:0]  ERR_FAIL  = 8'h01;
  localparam logic [7:0]  PROF1     = 8'h01;
  localparam logic [7:0]  PROF2     = 8'h02;
  localparam logic [7:0]  PROF3     = 8'h03;
  localparam logic [7:0]  PROF4     = 8'h04;

  typedef struct packed {
    logic signed [31:0] limit;
    logic [9:0]         sel;
    logic               op;
    logic [9:0]         lead;
  } lm_cmp_cfg_type;

  typedef struct packed {
    logic       gate_or;
    logic       inv;
    logic [9:0] min_on;
  } lm_grp_cfg_type;

  typedef struct packed {
    logic               vld;
    logic [9:0]         addr;
    logic signed [31:0] val;
  } lm_mv_type;

  typedef struct packed {
    logic        we;
    logic [14:0] blk;
    logic [4:0]  idx;
    logic [7:0]  data;
  } lm_mem_type;

  typedef enum logic {LM_IDLE, LM_WRITE} lm_wst_type;
endpackage : lm_pkg

// *** src/lm_cmp.sv ***
// One comparator with lead-time filter and violation time counter
`timescale 1ns/1ps
module lm_cmp (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rstn,
  // Timing and configuration
  input  wire logic                   i_tick,
  input  wire lm_pkg::lm_cmp_cfg_type i_cfg,
  // Measured values and external result
  input  wire lm_pkg::lm_mv_type      i_mv,
  input  wire logic                   i_ext,
  // Results
  output logic                        o_res,
  output logic                        o_act,
  output logic [31:0]                 o_run
);
  typedef struct packed {
    logic signed [31:0] mv;
    logic [9:0]         cnt;
    logic               res;
    logic [31:0]        run;
  } lm_cmp_st_type;

  lm_cmp_st_type q;
  lm_cmp_st_type n;
  logic          viol;
  logic          raw;
  logic          inrng;

  always_comb begin
    inrng = (i_cfg.sel >= lm_pkg::SEL_LO) && (i_cfg.sel <= lm_pkg::SEL_HI);
    viol  = (i_cfg.op == lm_pkg::OP_GE) ? (q.mv >= i_cfg.limit)
                                        : (q.mv < i_cfg.limit);
    raw   = inrng & viol;
    n     = q;
    if (i_mv.vld && i_mv.addr == i_cfg.sel) begin
      n.mv = i_mv.val;
    end
    if (i_cfg.sel == lm_pkg::SEL_EXT) begin
      n.res = i_ext;
      n.cnt = '0;
    end else if (raw == q.res) begin
      n.cnt = '0;
    end else if (i_tick) begin
      if (10'(q.cnt + 10'h001) >= i_cfg.lead) begin
        n.res = raw;
        n.cnt = '0;
      end else begin
        n.cnt = 10'(q.cnt + 10'h001);
      end
    end
    if (i_tick && q.res) begin
      n.run = 32'(q.run + 32'h0000_0001);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign o_res = q.res;
  assign o_act = (i_cfg.sel != lm_pkg::SEL_OFF);
  assign o_run = q.run;

  property p_lead;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_cfg.sel != lm_pkg::SEL_EXT && !i_tick) |=> $stable(q.res);
  endproperty
  a_lead: assert property (p_lead)
    else $error("comparator result changed without a second tick");

  property p_run;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_tick && q.res) |=> (q.run == 32'($past(q.run) + 32'h0000_0001));
  endproperty
  a_run: assert property (p_run)
    else $error("violation time did not advance");
endmodule : lm_cmp

// *** src/lm_grp.sv ***
// Group gate, minimum on-time hold and optional inversion
`timescale 1ns/1ps
module lm_grp (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rstn,
  // Timing and configuration
  input  wire logic                   i_tick,
  input  wire lm_pkg::lm_grp_cfg_type i_cfg,
  // Comparator results
  input  wire logic [2:0]             i_res,
  input  wire logic [2:0]             i_act,
  // Total result
  output logic                        o_tot
);
  typedef struct packed {
    logic       hold;
    logic [9:0] cnt;
    logic       tot;
  } lm_grp_st_type;

  lm_grp_st_type q;
  lm_grp_st_type n;
  logic          g;

  always_comb begin
    // Inactive comparators take no part in the gate
    g = i_cfg.gate_or ? |(i_res & i_act)
                      : ((|i_act) & (&(i_res | ~i_act)));
    n = q;
    if (g && !q.hold) begin
      n.hold = 1'b1;
      n.cnt  = i_cfg.min_on;
    end else if (q.hold) begin
      if (i_tick && q.cnt != 10'h000) begin
        n.cnt = 10'(q.cnt - 10'h001);
      end
      if (!g && q.cnt == 10'h000) begin
        n.hold = 1'b0;
      end
    end
    n.tot = n.hold ^ i_cfg.inv;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign o_tot = q.tot;

  property p_minon;
    @(posedge i_clk) disable iff (!i_rstn)
      (q.hold && q.cnt != 10'h000) |=> q.hold;
  endproperty
  a_minon: assert property (p_minon)
    else $error("group result dropped before minimum on-time");

  property p_gate;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_cfg.gate_or && |(i_res & i_act)) |=> q.hold;
  endproperty
  a_gate: assert property (p_gate)
    else $error("or gate did not raise group result");
endmodule : lm_grp

// *** src/lm_top.sv ***
// Limit monitor with six comparators, two groups and block logger
//
// Functional notes
// - Each comparator holds a signed 32-bit limit and compares its value
// - Group result, once active, stays on for the programmed minimum time
// - Comparator result changes only after the lead time has passed; an external result (selector 001) is taken at once
// - Operator 0 flags value >= limit, operator 1 flags value < limit
// - Comparator result is 0 without violation, 1 with violation
// - Each comparator sums the seconds its result showed a violation
// - Three results of a group combine by an AND or an OR gate
// - The gated group result may be inverted before output
// - With profile 4 enabled, every comparator change is logged
// - Log is circular, 32768 blocks of 18 bytes, oldest overwritten
// - Block: record number, time stamp, data, profile, error byte
// - Time stamp holds seconds since 1.1.1970 at storing time
// - Error byte is 0 when valid, nonzero if phases failed mid-store
// - Record selection bit k-1 enables profile k
// - After power returns, storing resumes at averaging period expiry
// - Sync rising edge saves profile 1 and restarts the power period
// - Profile 1 saved per power period, profile 2 per current period
// - Profile 3 energy counters saved once an hour
// - Profile 4 byte n holds comparator bits 1..6 at stamp plus n sec
// - Selector 000 inactive, 001 external, 200..400 measured values
// - Two groups of three; group totals drive digital outputs 1, 2
`timescale 1ns/1ps
module lm_top #(
  parameter int TICK_DIV = lm_pkg::SEC_CYC
) (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rstn,
  // Comparator and group configuration
  input  wire lm_pkg::lm_cmp_cfg_type [5:0] i_cmp_cfg,
  input  wire lm_pkg::lm_grp_cfg_type [1:0] i_grp_cfg,
  // Measured values and external results
  input  wire lm_pkg::lm_mv_type      i_mv,
  input  wire logic [5:0]             i_ext_res,
  // Recording configuration and profile data
  input  wire logic [3:0]             i_rec_sel,
  input  wire logic [15:0]            i_pavg_s,
  input  wire logic [15:0]            i_iavg_s,
  input  wire logic [79:0]            i_p1_data,
  input  wire logic [79:0]            i_p2_data,
  input  wire logic [79:0]            i_p3_data,
  // Real time setting
  input  wire logic                   i_time_set,
  input  wire logic [31:0]            i_time_val,
  // Pins
  input  wire logic                   i_sync,
  input  wire logic                   i_phase_fail,
  // Data memory
  input  wire logic                   i_mem_rdy,
  output lm_pkg::lm_mem_type          o_mem,
  // Results
  output logic [1:0]                  o_dout,
  output logic [5:0]                  o_cmp_res,
  output logic [5:0][31:0]            o_run_time,
  output logic [31:0]                 o_time,
  output logic                        o_log_busy
);
  typedef struct packed {
    logic [26:0]        div;
    logic               tick;
    logic [31:0]        ts;
    logic [11:0]        hr;
    logic [15:0]        pcnt;
    logic [15:0]        icnt;
    logic               sync_m;
    logic               sync_s;
    logic               sync_l;
    logic               fail_m;
    logic               fail_s;
    logic               inhib;
    logic [3:0]         pend;
    logic               p4cap;
    logic [3:0]         p4n;
    logic [31:0]        p4ts;
    logic [79:0]        p4buf;
    logic [5:0]         p4last;
    lm_pkg::lm_wst_type wst;
    logic [4:0]         widx;
    logic [14:0]        wblk;
    logic [15:0]        rec;
    logic [31:0]        wts;
    logic [79:0]        wdata;
    logic [7:0]         wprof;
    logic               werr;
    lm_pkg::lm_mem_type mem;
  } lm_top_st_type;

  lm_top_st_type q;
  lm_top_st_type n;
  logic [5:0]    cres;
  logic [5:0]    cact;
  logic [1:0]    gtot;
  logic [3:0]    set;
  logic [3:0]    take;
  logic          p_exp;
  logic          i_exp;
  logic          h_exp;
  logic          sync_rise;
  logic          ok;
  logic [7:0]    err_b;

  genvar gi;
  generate
    for (gi = 0; gi < lm_pkg::NALL; gi++) begin : g_cmp
      lm_cmp u_cmp (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_tick (q.tick),
        .i_cfg  (i_cmp_cfg[gi]),
        .i_mv   (i_mv),
        .i_ext  (i_ext_res[gi]),
        .o_res  (cres[gi]),
        .o_act  (cact[gi]),
        .o_run  (o_run_time[gi])
      );
    end
    for (gi = 0; gi < lm_pkg::NGRP; gi++) begin : g_grp
      lm_grp u_grp (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_tick (q.tick),
        .i_cfg  (i_grp_cfg[gi]),
        .i_res  (cres[gi*lm_pkg::NCMP +: lm_pkg::NCMP]),
        .i_act  (cact[gi*lm_pkg::NCMP +: lm_pkg::NCMP]),
        .o_tot  (gtot[gi])
      );
    end
  endgenerate

  // Byte of the block being written
  function automatic logic [7:0] blk_byte(
    input logic [4:0]  idx,
    input logic [15:0] rec,
    input logic [31:0] ts,
    input logic [79:0] data,
    input logic [7:0]  prof,
    input logic [7:0]  err
  );
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      lm_pkg::OFS_REC:          b = rec[15:8];
      lm_pkg::OFS_REC + 5'h01:  b = rec[7:0];
      lm_pkg::OFS_TS:           b = ts[31:24];
      lm_pkg::OFS_TS + 5'h01:   b = ts[23:16];
      lm_pkg::OFS_TS + 5'h02:   b = ts[15:8];
      lm_pkg::OFS_TS + 5'h03:   b = ts[7:0];
      lm_pkg::OFS_PROF:         b = prof;
      lm_pkg::OFS_ERR:          b = err;
      default:                  b = 8'(data >> {idx - lm_pkg::OFS_DATA, 3'b000});
    endcase
    return b;
  endfunction : blk_byte

  always_comb begin
    n        = q;
    set      = 4'h0;
    take     = 4'h0;
    // One second tick
    n.tick   = 1'b0;
    if (q.div == 27'(TICK_DIV - 1)) begin
      n.div  = '0;
      n.tick = 1'b1;
    end else begin
      n.div  = 27'(q.div + 27'h000_0001);
    end
    if (i_time_set) begin
      n.ts = i_time_val;
    end else if (q.tick) begin
      n.ts = 32'(q.ts + 32'h0000_0001);
    end
    // Pin synchronisers
    n.sync_m  = i_sync;
    n.sync_s  = q.sync_m;
    n.sync_l  = q.sync_s;
    n.fail_m  = i_phase_fail;
    n.fail_s  = q.fail_m;
    sync_rise = q.sync_s & ~q.sync_l;
    // Period timers
    p_exp = q.tick && (16'(q.pcnt + 16'h0001) >= i_pavg_s);
    i_exp = q.tick && (16'(q.icnt + 16'h0001) >= i_iavg_s);
    h_exp = q.tick && (q.hr == lm_pkg::HOUR_LAST);
    if (sync_rise || p_exp) begin
      n.pcnt = '0;
    end else if (q.tick) begin
      n.pcnt = 16'(q.pcnt + 16'h0001);
    end
    if (i_exp) begin
      n.icnt = '0;
    end else if (q.tick) begin
      n.icnt = 16'(q.icnt + 16'h0001);
    end
    if (h_exp) begin
      n.hr = '0;
    end else if (q.tick) begin
      n.hr = 12'(q.hr + 12'h001);
    end
    // Storing held off from power loss until an averaging period ends
    ok = !q.fail_s && (!q.inhib || p_exp || i_exp);
    if (q.fail_s) begin
      n.inhib = 1'b1;
    end else if (p_exp || i_exp) begin
      n.inhib = 1'b0;
    end
    set[0] = ok && i_rec_sel[0] && (p_exp || sync_rise);
    set[1] = ok && i_rec_sel[1] && i_exp;
    set[2] = ok && i_rec_sel[2] && h_exp;
    // Profile 4 capture of ten one-second samples
    if (!q.p4cap) begin
      if (i_rec_sel[3] && ok && cres != q.p4last) begin
        n.p4cap  = 1'b1;
        n.p4ts   = q.ts;
        n.p4n    = 4'h1;
        n.p4last = cres;
        n.p4buf  = {1'b0, cres, 1'b0, q.p4buf[79:8]};
      end
    end else if (q.tick) begin
      n.p4buf = {1'b0, cres, 1'b0, q.p4buf[79:8]};
      n.p4n   = 4'(q.p4n + 4'h1);
      if (q.p4n == lm_pkg::P4_LAST) begin
        n.p4cap  = 1'b0;
        n.p4last = cres;
        set[3]   = i_rec_sel[3];
      end
    end
    // Block writer
    err_b = (q.werr || q.fail_s) ? lm_pkg::ERR_FAIL : lm_pkg::ERR_OK;
    case (q.wst)
      lm_pkg::LM_IDLE: begin
        if (q.pend != 4'h0) begin
          n.wst  = lm_pkg::LM_WRITE;
          n.widx = '0;
          n.werr = 1'b0;
          n.wts  = q.ts;
          if (q.pend[0]) begin
            take    = 4'b0001;
            n.wdata = i_p1_data;
            n.wprof = lm_pkg::PROF1;
          end else if (q.pend[1]) begin
            take    = 4'b0010;
            n.wdata = i_p2_data;
            n.wprof = lm_pkg::PROF2;
          end else if (q.pend[2]) begin
            take    = 4'b0100;
            n.wdata = i_p3_data;
            n.wprof = lm_pkg::PROF3;
          end else begin
            take    = 4'b1000;
            n.wdata = q.p4buf;
            n.wprof = lm_pkg::PROF4;
            n.wts   = q.p4ts;
          end
        end
      end
      lm_pkg::LM_WRITE: begin
        if (q.fail_s) begin
          n.werr = 1'b1;
        end
        if (!q.mem.we || i_mem_rdy) begin
          if (q.widx == lm_pkg::BLK_LEN) begin
            n.mem.we = 1'b0;
            n.wst    = lm_pkg::LM_IDLE;
            n.rec    = 16'(q.rec + 16'h0001);
            n.wblk   = 15'(q.wblk + 15'h0001);
          end else begin
            n.mem.we   = 1'b1;
            n.mem.blk  = q.wblk;
            n.mem.idx  = q.widx;
            n.mem.data = blk_byte(q.widx, q.rec, q.wts, q.wdata,
                                  q.wprof, err_b);
            n.widx     = 5'(q.widx + 5'h01);
          end
        end
      end
      default: n.wst = lm_pkg::LM_IDLE;
    endcase
    // A new request wins over the clear of its flag
    n.pend = (q.pend & ~take) | set;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign o_mem      = q.mem;
  assign o_dout     = gtot;
  assign o_cmp_res  = cres;
  assign o_time     = q.ts;
  assign o_log_busy = (q.wst == lm_pkg::LM_WRITE);

  property p_tick;
    @(posedge i_clk) disable iff (!i_rstn)
      q.tick |=> !q.tick;
  endproperty
  a_tick: assert property (p_tick)
    else $error("second tick longer than one cycle");

  property p_ts;
    @(posedge i_clk) disable iff (!i_rstn)
      (q.tick && !i_time_set) |=> (q.ts == 32'($past(q.ts) + 32'h0000_0001));
  endproperty
  a_ts: assert property (p_ts)
    else $error("time stamp did not advance on tick");

  property p_sync;
    @(posedge i_clk) disable iff (!i_rstn)
      (sync_rise && i_rec_sel[0] && !q.fail_s && !q.inhib)
        |=> (q.pend[0] && q.pcnt == 16'h0000);
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync edge did not request profile 1");

  property p_end;
    @(posedge i_clk) disable iff (!i_rstn)
      $rose(q.wst == lm_pkg::LM_IDLE)
        |-> (q.rec == 16'($past(q.rec) + 16'h0001)
             && q.wblk == 15'($past(q.wblk) + 15'h0001));
  endproperty
  a_end: assert property (p_end)
    else $error("record number or block pointer not advanced");

  property p_fail;
    @(posedge i_clk) disable iff (!i_rstn)
      q.fail_s |=> ((q.pend[2:0] & ~$past(q.pend[2:0])) == 3'h0);
  endproperty
  a_fail: assert property (p_fail)
    else $error("profile requested during phase failure");

  property p_prof;
    @(posedge i_clk) disable iff (!i_rstn)
      (q.mem.we && q.mem.idx == lm_pkg::OFS_PROF) |-> (q.mem.data == q.wprof);
  endproperty
  a_prof: assert property (p_prof)
    else $error("profile byte misplaced");

  property p_p4;
    @(posedge i_clk) disable iff (!i_rstn)
      (q.p4cap && q.tick && q.p4n == lm_pkg::P4_LAST && i_rec_sel[3])
        |=> (!q.p4cap && q.pend[3]);
  endproperty
  a_p4: assert property (p_p4)
    else $error("profile 4 capture did not end after ten samples");

  c_p4:   cover property (@(posedge i_clk) disable iff (!i_rstn)
    q.mem.we && q.wprof == lm_pkg::PROF4);
  c_sync: cover property (@(posedge i_clk) disable iff (!i_rstn)
    sync_rise && i_rec_sel[0]);
  c_dout: cover property (@(posedge i_clk) disable iff (!i_rstn)
    $rose(o_dout[0]));
  c_err:  cover property (@(posedge i_clk) disable iff (!i_rstn)
    q.mem.we && q.mem.idx == lm_pkg::OFS_ERR && q.mem.data != 8'h00);
endmodule : lm_top

// *** testbench/lm_mem_model.sv ***
// Data memory model that gathers byte writes into 18-byte blocks
`timescale 1ns/1ps
module lm_mem_model (
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rstn,
  // Byte write port
  input  wire lm_pkg::lm_mem_type i_mem,
  output logic                    o_rdy,
  // Completed block
  output logic                    o_done,
  output logic [143:0]            o_blk,
  output logic [14:0]             o_num,
  output logic                    o_bad
);
  logic [4:0] cnt_q;

  always @(posedge i_clk) begin
    o_done <= 1'b0;
    if (!i_rstn) begin
      o_rdy <= 1'b0;
      o_bad <= 1'b0;
      cnt_q <= 5'h00;
    end else begin
      // Random stalls, about one cycle in three
      o_rdy <= ($urandom % 3) != 0;
      if (i_mem.we && o_rdy) begin
        o_bad <= o_bad | (i_mem.idx != cnt_q);
        o_blk[8 * (17 - i_mem.idx) +: 8] <= i_mem.data;
        o_num <= i_mem.blk;
        cnt_q <= (i_mem.idx == 5'h11) ? 5'h00 : cnt_q + 5'h01;
        o_done <= (i_mem.idx == 5'h11);
      end
    end
  end
endmodule : lm_mem_model

// *** testbench/lm_top_tb.sv ***
// Self-checking bench of the limit monitor and block logger
`timescale 1ns/1ps
module lm_top_tb;
  typedef struct packed {
    logic [15:0] rec;
    logic [79:0] data;
    logic [7:0]  prof;
    logic [7:0]  err;
  } lm_note_type;
  logic                         i_clk = 1'b0;
  logic                         i_rstn = 1'b0;
  lm_pkg::lm_cmp_cfg_type [5:0] cmp_cfg = '0;
  lm_pkg::lm_grp_cfg_type [1:0] grp_cfg = '0;
  lm_pkg::lm_mv_type            mv = '0;
  logic [5:0]                   ext = '0;
  logic [3:0]                   rec_sel = '0;
  logic [79:0]                  p1, p1r, p2, p2r, p3, p3r;
  logic [15:0]                  iavg = 16'h03E8;
  logic                         tset = 1'b0;
  logic [31:0]                  tval = '0;
  logic                         sync = 1'b0;
  logic                         pfail = 1'b0;
  logic                         rdy, done, bad, busy;
  lm_pkg::lm_mem_type           mem;
  logic [1:0]                   dout;
  logic [5:0]                   res;
  logic [5:0][31:0]             run;
  logic [31:0]                  tm, t0, r0;
  logic [143:0]                 blk;
  logic [14:0]                  bnum;
  logic signed [31:0]           lim;
  lm_note_type                  exp_q[$];
  lm_note_type                  n;
  int                           n_errors = 0;
  int                           check_count = 0;
  int                           cyc = 0;

  always #5 i_clk = ~i_clk;

  lm_top #(.TICK_DIV(10)) lm_top_i (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_cmp_cfg(cmp_cfg),
    .i_grp_cfg(grp_cfg), .i_mv(mv), .i_ext_res(ext), .i_rec_sel(rec_sel),
    .i_pavg_s(16'h03E8), .i_iavg_s(iavg), .i_p1_data(p1),
    .i_p2_data(p2), .i_p3_data(p3), .i_time_set(tset),
    .i_time_val(tval), .i_sync(sync), .i_phase_fail(pfail),
    .i_mem_rdy(rdy), .o_mem(mem), .o_dout(dout), .o_cmp_res(res),
    .o_run_time(run), .o_time(tm), .o_log_busy(busy));

  lm_mem_model lm_mem_model_i (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_mem(mem), .o_rdy(rdy),
    .o_done(done), .o_blk(blk), .o_num(bnum), .o_bad(bad));

  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic cy(input int k);
    repeat (k) @(posedge i_clk);
  endtask : cy

  task automatic send(input logic signed [31:0] v);
    @(posedge i_clk);
    mv <= {1'b1, lm_pkg::SEL_LO, v};
    @(posedge i_clk);
    mv.vld <= 1'b0;
  endtask : send

  task automatic settime();
    t0 = $urandom;
    @(posedge i_clk);
    tset <= 1'b1;
    tval <= t0;
    @(posedge i_clk);
    tset <= 1'b0;
  endtask : settime

  task automatic drain();
    for (int k = 0; k < 600 && exp_q.size() != 0; k++) @(posedge i_clk);
    check(80'(exp_q.size()), 80'h0);
  endtask : drain

  task automatic results();
    $display("Checks: %0d, errors: %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  // Each finished block is matched to the oldest expected note
  always @(posedge i_clk) begin
    if (done) begin
      if (exp_q.size() == 0) begin
        check(80'h1, 80'h0);
      end else begin
        n = exp_q.pop_front();
        check(80'(blk[143:128]), 80'(n.rec));
        check(80'(blk[127:96] - t0 <= 32'h1), 80'h1);
        check(blk[95:16], n.data);
        check(80'(blk[15:8]), 80'(n.prof));
        check(80'(blk[7:0]), 80'(n.err));
        check(80'({bad, bnum}), 80'(n.rec));
        check(80'(busy), 80'h0);
      end
    end
  end

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      results();
    end
  end

  initial begin
    void'($urandom(1753));
    p1 = {$urandom, $urandom, 16'($urandom)};
    p1r = {<<8{p1}};
    p2 = {$urandom, $urandom, 16'($urandom)};
    p2r = {<<8{p2}};
    p3 = {$urandom, $urandom, 16'($urandom)};
    p3r = {<<8{p3}};
    grp_cfg[0] = {1'b1, 1'b0, 10'd4};
    grp_cfg[1] = {1'b1, 1'b0, 10'd4};
    cy(8);
    i_rstn <= 1'b1;
    cy(2);
    check(80'({tm, run[0], dout, res, mem.we, busy}), 80'h0);
    for (int op = 0; op < 2; op++) begin
      lim = $signed($urandom) >>> 2;
      cmp_cfg[0] <= {lim, lm_pkg::SEL_LO, op[0], 10'd2};
      send(lim - 1);
      cy(60);
      check(80'(res[0]), 80'(op[0]));
      send(lim);
      cy(60);
      check(80'(res[0]), 80'(!op[0]));
    end
    // Short violation must be filtered out, a long one passes
    cmp_cfg[0].op <= lm_pkg::OP_GE;
    cmp_cfg[0].lead <= 10'd3;
    send(lim - 1);
    cy(60);
    send(lim);
    cy(15);
    send(lim - 1);
    cy(60);
    check(80'(res[0]), 80'h0);
    send(lim);
    cy(15);
    check(80'(res[0]), 80'h0);
    cy(30);
    check(80'(res[0]), 80'h1);
    r0 = run[0];
    cy(50);
    check(80'(run[0] - r0), 80'd5);
    check(80'(dout[0]), 80'h1);
    cmp_cfg[1].sel <= lm_pkg::SEL_EXT;
    cmp_cfg[3].sel <= lm_pkg::SEL_EXT;
    grp_cfg[0].gate_or <= 1'b0;
    cy(60);
    check(80'(dout[0]), 80'h0);
    ext[1] <= 1'b1;
    cy(8);
    check(80'(dout[0]), 80'h1);
    ext[1] <= 1'b0;
    cy(20);
    check(80'(dout[0]), 80'h1);
    cy(40);
    check(80'(dout[0]), 80'h0);
    grp_cfg[0].inv <= 1'b1;
    ext[3] <= 1'b1;
    cy(8);
    check(80'({dout, res[3]}), 80'h7);
    // All results back to zero before logging starts
    grp_cfg[0].inv <= 1'b0;
    ext[3] <= 1'b0;
    send(lim - 1);
    cy(60);
    rec_sel <= 4'b1001;
    settime();
    exp_q.push_back({16'h0, p1r, lm_pkg::PROF1, lm_pkg::ERR_OK});
    sync <= 1'b1;
    drain();
    settime();
    exp_q.push_back({16'h1, {10{8'h10}}, lm_pkg::PROF4, lm_pkg::ERR_OK});
    ext[3] <= 1'b1;
    drain();
    sync <= 1'b0;
    cy(4);
    settime();
    exp_q.push_back({16'h2, p1r, lm_pkg::PROF1, lm_pkg::ERR_FAIL});
    sync <= 1'b1;
    cy(8);
    pfail <= 1'b1;
    cy(3);
    check(80'(busy), 80'h1);
    pfail <= 1'b0;
    drain();
    // Sync after a failure is ignored until a period expires
    sync <= 1'b0;
    cy(4);
    sync <= 1'b1;
    cy(150);
    // Current period expiry ends the hold-off and stores profile 2
    settime();
    rec_sel <= 4'b0010;
    iavg <= 16'h0014;
    exp_q.push_back({16'h3, p2r, lm_pkg::PROF2, lm_pkg::ERR_OK});
    drain();
    rec_sel <= 4'b0000;
    // Hour mark falls at cycle 36009
    wait (cyc == 36000);
    settime();
    rec_sel <= 4'b0100;
    exp_q.push_back({16'h4, p3r, lm_pkg::PROF3, lm_pkg::ERR_OK});
    drain();
    results();
  end
endmodule : lm_top_tb
